/* rtl/power_event_irq_regs.sv */
/*
  Register slice of the power-control unit: publish configuration for the sleep
  events, interrupt enable with set and clear views, sticky event status, and
  retained scratch words.
  Assumes a synchronous register port with single-cycle strobes, a processor
  sleep level and a power-fail warning pulse, all synchronous to clock_i.
*/
`timescale 1ns/1ns
module power_event_irq_regs (
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_b_i,
	// Register port
	input  wire logic [11:0] addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// Event sources
	input  wire logic        power_fail_warning_i,
	input  wire logic        cpu_sleeping_i,
	// Event channel interconnect
	output logic             sleep_entry_publish_o,
	output logic      [7:0]  sleep_entry_channel_o,
	output logic             sleep_exit_publish_o,
	output logic      [7:0]  sleep_exit_channel_o,
	// Processor interrupt
	output logic             irq_o
);
	// Address decode, used by both the write and the read path
	function automatic logic is_scratch(input logic [11:0] a);
		return (a == power_event_pkg::RETAINED_SCRATCH_OFFSET) ||
			(a == power_event_pkg::RETAINED_SCRATCH_OFFSET +
			power_event_pkg::RETAINED_SCRATCH_STRIDE);
	endfunction

	function automatic logic [31:0] event_bits(input logic pf, input logic en, input logic ex);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[power_event_pkg::POWER_FAIL_WARNING_BIT] = pf;
		v[power_event_pkg::SLEEP_ENTRY_BIT]        = en;
		v[power_event_pkg::SLEEP_EXIT_BIT]         = ex;
		return v;
	endfunction

	logic [31:0]                         sleep_entry_publish_cfg;
	logic [31:0]                         sleep_exit_publish_cfg;
	logic [31:0]                         irq_enable_mask;
	logic [31:0]                         event_status;
	power_event_pkg::sleep_state_t       sleep_state;
	power_event_pkg::sleep_state_t       next_sleep_state;
	logic                                sleep_entry_event;
	logic                                sleep_exit_event;
	logic                                power_fail_warning_event;
	logic [31:0]                         event_now;
	logic [31:0]                         next_rdata;

	scratch_if scratch ();

	retained_scratch_store u_scratch (
		.clock_i (clock_i),
		.port    (scratch.store)
	);

	// Scratch index comes from address bit 2, the lowest of the bits 2 to 5 in which the two word addresses differ
	assign scratch.write      = wr_i && is_scratch(addr_i);
	assign scratch.index      = addr_i[2] ^ power_event_pkg::RETAINED_SCRATCH_OFFSET[2];
	assign scratch.write_data = wdata_i;

	// Sleep tracker: events come from edges of the processor sleep level
	always_comb begin
		next_sleep_state  = sleep_state;
		sleep_entry_event = 1'b0;
		sleep_exit_event  = 1'b0;
		case (sleep_state)
			power_event_pkg::CPU_AWAKE: begin
				if (cpu_sleeping_i) begin
					next_sleep_state  = power_event_pkg::CPU_ASLEEP;
					sleep_entry_event = 1'b1;
				end
			end
			power_event_pkg::CPU_ASLEEP: begin
				if (!cpu_sleeping_i) begin
					next_sleep_state = power_event_pkg::CPU_AWAKE;
					sleep_exit_event = 1'b1;
				end
			end
			default: begin
				next_sleep_state = power_event_pkg::CPU_AWAKE;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			sleep_state <= power_event_pkg::CPU_AWAKE;
		end else begin
			sleep_state <= next_sleep_state;
		end
	end

	assign power_fail_warning_event = power_fail_warning_i;
	assign event_now = event_bits(power_fail_warning_event, sleep_entry_event,
		sleep_exit_event);

	// Publish configuration
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			sleep_entry_publish_cfg <= power_event_pkg::PUBLISH_CFG_RESET;
			sleep_exit_publish_cfg  <= power_event_pkg::PUBLISH_CFG_RESET;
		end else if (wr_i) begin
			if (addr_i == power_event_pkg::SLEEP_ENTRY_PUBLISH_CFG_OFFSET) begin
				sleep_entry_publish_cfg <= wdata_i;
			end else if (addr_i == power_event_pkg::SLEEP_EXIT_PUBLISH_CFG_OFFSET) begin
				sleep_exit_publish_cfg <= wdata_i;
			end
		end
	end

	// Publish strobes: one cycle per event, channel held beside it
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			sleep_entry_publish_o <= 1'b0;
			sleep_entry_channel_o <= 8'h00;
			sleep_exit_publish_o  <= 1'b0;
			sleep_exit_channel_o  <= 8'h00;
		end else begin
			sleep_entry_publish_o <= sleep_entry_event &&
				sleep_entry_publish_cfg[power_event_pkg::PUBLISH_ENABLE_BIT];
			sleep_entry_channel_o <= sleep_entry_publish_cfg[
				power_event_pkg::CHANNEL_INDEX_LSB +:
				power_event_pkg::CHANNEL_INDEX_WIDTH];
			sleep_exit_publish_o  <= sleep_exit_event &&
				sleep_exit_publish_cfg[power_event_pkg::PUBLISH_ENABLE_BIT];
			sleep_exit_channel_o  <= sleep_exit_publish_cfg[
				power_event_pkg::CHANNEL_INDEX_LSB +:
				power_event_pkg::CHANNEL_INDEX_WIDTH];
		end
	end

	// One enable state behind the plain, set and clear views
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			irq_enable_mask <= power_event_pkg::IRQ_ENABLE_RESET;
		end else if (wr_i) begin
			if (addr_i == power_event_pkg::IRQ_ENABLE_MASK_OFFSET) begin
				irq_enable_mask <= wdata_i & power_event_pkg::IRQ_BITS_USED;
			end else if (addr_i == power_event_pkg::IRQ_ENABLE_SET_OFFSET) begin
				irq_enable_mask <= irq_enable_mask |
					(wdata_i & power_event_pkg::IRQ_BITS_USED);
			end else if (addr_i == power_event_pkg::IRQ_ENABLE_CLEAR_OFFSET) begin
				irq_enable_mask <= irq_enable_mask & ~wdata_i;
			end
		end
	end

	// Sticky event flags; a new event wins over a write-one-to-clear
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			event_status <= power_event_pkg::EVENT_STATUS_RESET;
		end else if (wr_i && addr_i == power_event_pkg::EVENT_STATUS_OFFSET) begin
			event_status <= (event_status & ~wdata_i) | event_now;
		end else begin
			event_status <= event_status | event_now;
		end
	end

	// Level interrupt; registered, so it follows the flags by one cycle
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(event_status & irq_enable_mask);
		end
	end

	// Read mux; unmapped addresses read as zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (addr_i == power_event_pkg::SLEEP_ENTRY_PUBLISH_CFG_OFFSET) begin
			next_rdata = sleep_entry_publish_cfg;
		end else if (addr_i == power_event_pkg::SLEEP_EXIT_PUBLISH_CFG_OFFSET) begin
			next_rdata = sleep_exit_publish_cfg;
		end else if (addr_i == power_event_pkg::IRQ_ENABLE_MASK_OFFSET ||
				addr_i == power_event_pkg::IRQ_ENABLE_SET_OFFSET ||
				addr_i == power_event_pkg::IRQ_ENABLE_CLEAR_OFFSET) begin
			next_rdata = irq_enable_mask;
		end else if (addr_i == power_event_pkg::EVENT_STATUS_OFFSET) begin
			next_rdata = event_status;
		end else if (is_scratch(addr_i)) begin
			next_rdata = scratch.read_data;
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i) begin
			rdata_o <= next_rdata;
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end
endmodule

/* rtl/power_event_pkg.sv */
/*
  Constants for the power-event interrupt and publish register slice.
  Assumes a 32-bit register port with word-aligned byte addresses.
*/
// Behaviour
// - A sleep-entry publish register at 0x194 holds a channel index and an enable, zero at reset.
// - A sleep-exit publish register at 0x198 has the same channel index and enable fields.
// - With its enable at 1 each event is sent on the chosen channel 0..255; at 0 nothing is sent.
// - The enable register at 0x300 holds one bit per event (power-fail, entry, exit), zero at reset.
// - An enable bit at 0 blocks and at 1 allows the interrupt of its event.
// - Writing a one to a bit at 0x304 enables that event's interrupt.
// - Reading 0x304 returns the present enable bits.
// - Two retained scratch words sit at 0x51c and 0x520 and keep their contents over reset.
// - Sleep entry is flagged when the processor goes to sleep and sleep exit when it wakes.
package power_event_pkg;

	localparam logic [11:0] SLEEP_ENTRY_PUBLISH_CFG_OFFSET = 12'h194;
	localparam logic [11:0] SLEEP_EXIT_PUBLISH_CFG_OFFSET  = 12'h198;
	localparam logic [11:0] IRQ_ENABLE_MASK_OFFSET         = 12'h300;
	localparam logic [11:0] IRQ_ENABLE_SET_OFFSET          = 12'h304;
	localparam logic [11:0] IRQ_ENABLE_CLEAR_OFFSET        = 12'h308;
	localparam logic [11:0] EVENT_STATUS_OFFSET            = 12'h320;
	localparam logic [11:0] RETAINED_SCRATCH_OFFSET        = 12'h51c;
	localparam logic [11:0] RETAINED_SCRATCH_STRIDE        = 12'h004;
	localparam int          RETAINED_SCRATCH_COUNT         = 2;

	localparam int          CHANNEL_INDEX_LSB              = 0;
	localparam int          CHANNEL_INDEX_WIDTH            = 8;
	localparam int          PUBLISH_ENABLE_BIT             = 31;
	localparam logic [31:0] PUBLISH_CFG_RESET              = 32'h0000_0000;

	localparam int          POWER_FAIL_WARNING_BIT         = 2;
	localparam int          SLEEP_ENTRY_BIT                = 5;
	localparam int          SLEEP_EXIT_BIT                 = 6;
	localparam logic [31:0] IRQ_BITS_USED                  = 32'h0000_0064;
	localparam logic [31:0] IRQ_ENABLE_RESET               = 32'h0000_0000;
	localparam logic [31:0] EVENT_STATUS_RESET             = 32'h0000_0000;

	typedef enum logic [0:0] {
		CPU_AWAKE  = 1'b0,
		CPU_ASLEEP = 1'b1
	} sleep_state_t;

endpackage

/* rtl/scratch_if.sv */
/*
  Carrier between the register slice and its retained scratch store.
  Assumes both ends share clock_i.
*/
`timescale 1ns/1ns
interface scratch_if;
	logic        write;
	logic [0:0]  index;
	logic [31:0] write_data;
	logic [31:0] read_data;

	modport owner (output write, output index, output write_data, input read_data);
	modport store (input write, input index, input write_data, output read_data);
endinterface

/* rtl/retained_scratch_store.sv */
/*
  Retained scratch words. Contents have no reset so they survive a system reset.
  Assumes the owner presents one write at a time; the read is a plain select of stored flops.
*/
`timescale 1ns/1ns
module retained_scratch_store (
	// Clock
	input  wire logic   clock_i,
	// Owner side
	scratch_if.store    port
);
	logic [31:0] words [power_event_pkg::RETAINED_SCRATCH_COUNT];

	// Deliberately not reset: the words are retained
	always_ff @(posedge clock_i) begin
		if (port.write) begin
			words[port.index] <= port.write_data;
		end
	end

	assign port.read_data = words[port.index];
endmodule

/* dv/power_event_irq_regs_assertions.sv */
/*
  Checker on the ports of the power-event register slice.
  Assumes one clock domain and the synchronous active-low reset.
*/
`timescale 1ns/1ns
module power_event_irq_regs_checker (
	// Clock and reset
	input wire logic        clock_i,
	input wire logic        rst_b_i,
	// Register port
	input wire logic [11:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	// Events and outputs
	input wire logic        power_fail_warning_i,
	input wire logic        cpu_sleeping_i,
	input wire logic        sleep_entry_publish_o,
	input wire logic [7:0]  sleep_entry_channel_o,
	input wire logic        sleep_exit_publish_o,
	input wire logic [7:0]  sleep_exit_channel_o,
	input wire logic        irq_o
);
	default clocking dc @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);

	AST_ENTRY_CAUSE: assert property (sleep_entry_publish_o |-> $past(cpu_sleeping_i))
		else $error("entry pulse while awake");
	AST_EXIT_CAUSE: assert property (sleep_exit_publish_o |-> !$past(cpu_sleeping_i))
		else $error("exit pulse while asleep");
	AST_PUB_PULSE: assert property (sleep_entry_publish_o |=> !sleep_entry_publish_o)
		else $error("entry pulse too long");
	AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside its cycle");
	AST_MASK_BITS: assert property ($past(rd_i) && $past(addr_i) == 12'h300
		|-> (rdata_o & ~power_event_pkg::IRQ_BITS_USED) == 32'h0) else $error("unused bits set");
	AST_CLR_ALL: assert property (wr_i && addr_i == 12'h308
		&& &(wdata_i | ~power_event_pkg::IRQ_BITS_USED) ##1 !wr_i |=> !irq_o) else $error("irq kept");
	AST_IRQ_RISE: assert property ($rose(irq_o) |-> $past(wr_i, 2)
		|| $past(power_fail_warning_i, 2)
		|| $past(cpu_sleeping_i, 2) != $past(cpu_sleeping_i, 3)) else $error("irq without cause");
	// Reset itself also drops the interrupt and the channel; the release edge is still checked
	AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(wr_i, 2) || !$past(rst_b_i))
		else $error("irq fell without write");
	AST_CHAN: assert property ($changed(sleep_entry_channel_o)
		|-> $past(wr_i) || $past(wr_i, 2) || !$past(rst_b_i))
		else $error("channel changed without write");

	cover property (sleep_entry_publish_o);
	cover property (sleep_exit_publish_o);
	cover property ($rose(irq_o));
endmodule

bind power_event_irq_regs power_event_irq_regs_checker power_event_irq_regs_checker_inst (.*);

/* dv/power_event_partner.sv */
/*
  Event channel sink: counts publish pulses and keeps the last channel seen.
  Assumes one-cycle pulses on clock_i.
*/
`timescale 1ns/1ns
module power_event_partner (
	// Clock and reset
	input  wire logic       clock_i,
	input  wire logic       rst_b_i,
	// From the slice
	input  wire logic       entry_i,
	input  wire logic [7:0] entry_ch_i,
	input  wire logic       exit_i,
	input  wire logic [7:0] exit_ch_i,
	// To the bench
	output logic      [7:0] entries_o,
	output logic      [7:0] exits_o,
	output logic      [7:0] last_ch_o
);
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			entries_o <= 8'h00;
			exits_o   <= 8'h00;
			last_ch_o <= 8'h00;
		end else if (entry_i) begin
			entries_o <= entries_o + 8'h01;
			last_ch_o <= entry_ch_i;
		end else if (exit_i) begin
			exits_o   <= exits_o + 8'h01;
			last_ch_o <= exit_ch_i;
		end
	end
endmodule

/* dv/power_event_irq_regs_tb.sv */
/*
  Self-checking bench for the power-event register slice.
  Assumes the partner sink on the publish outputs.
*/
`timescale 1ns/1ns
module power_event_irq_regs_tb;
	logic        clock_i, rst_b_i, wr_i, rd_i, power_fail_warning_i, cpu_sleeping_i;
	logic        sleep_entry_publish_o, sleep_exit_publish_o, irq_o;
	logic [11:0] addr_i;
	logic [31:0] wdata_i, rdata_o;
	logic [7:0]  sleep_entry_channel_o, sleep_exit_channel_o, entries, exits, last_ch;
	logic [11:0] offs [5] = '{12'h194, 12'h198, 12'h300, 12'h304, 12'h308};
	int          err_total = 0;
	int          checks = 0;

	power_event_irq_regs power_event_irq_regs_inst (
		.clock_i               (clock_i),
		.rst_b_i               (rst_b_i),
		.addr_i                (addr_i),
		.wdata_i               (wdata_i),
		.wr_i                  (wr_i),
		.rd_i                  (rd_i),
		.rdata_o               (rdata_o),
		.power_fail_warning_i  (power_fail_warning_i),
		.cpu_sleeping_i        (cpu_sleeping_i),
		.sleep_entry_publish_o (sleep_entry_publish_o),
		.sleep_entry_channel_o (sleep_entry_channel_o),
		.sleep_exit_publish_o  (sleep_exit_publish_o),
		.sleep_exit_channel_o  (sleep_exit_channel_o),
		.irq_o                 (irq_o)
	);
	power_event_partner power_event_partner_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.entry_i(sleep_entry_publish_o), .entry_ch_i(sleep_entry_channel_o),
		.exit_i(sleep_exit_publish_o), .exit_ch_i(sleep_exit_channel_o),
		.entries_o(entries), .exits_o(exits), .last_ch_o(last_ch));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clock_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, e, "rdata");
	endtask
	// Event inputs move on an edge, then three edges let pulse and irq settle
	task automatic sleep(input logic s);
		@(posedge clock_i) cpu_sleeping_i <= s;
		repeat (3) @(posedge clock_i);
		#1;
	endtask
	task automatic do_reset;
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		rst_b_i <= 1'b1;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	// Whole run is well under 1000 cycles
	initial begin
		#20000;
		err_total++;
		wrap_up;
	end
	initial begin
		{rst_b_i, wr_i, rd_i, power_fail_warning_i, cpu_sleeping_i} = 5'h00;
		addr_i = 12'h000;
		wdata_i = 32'h0;
		do_reset;
		foreach (offs[i]) rd(offs[i], 32'h0);
		rd(12'h0fc, 32'h0);
		$display("test reset values done");
		wr(12'h304, 32'h0000_0020);
		for (int i = 2; i < 5; i++) rd(offs[i], 32'h20);
		wr(12'h308, 32'h0);
		rd(12'h300, 32'h20);
		wr(12'h304, 32'hffff_ffff);
		rd(12'h300, 32'h64);
		wr(12'h308, 32'h0000_0044);
		rd(12'h304, 32'h20);
		wr(12'h300, 32'h0000_0020);
		$display("test enable views done");
		wr(12'h194, 32'h8000_00a5);
		wr(12'h198, 32'h8000_005a);
		rd(12'h198, 32'h8000_005a);
		chk(sleep_entry_channel_o, 32'ha5, "entry channel out");
		sleep(1'b1);
		chk(entries, 32'h1, "entries");
		chk(last_ch, 32'ha5, "channel");
		chk(irq_o, 32'h1, "irq");
		sleep(1'b0);
		chk(exits, 32'h1, "exits");
		chk(last_ch, 32'h5a, "channel");
		// Clear only the entry flag, so the exit flag stays set behind a closed enable
		wr(12'h320, 32'h20);
		rd(12'h320, 32'h40);
		sleep(1'b0);
		chk(irq_o, 32'h0, "irq exit masked");
		// One-cycle warning pulse: each high cycle counts as one event
		@(posedge clock_i) power_fail_warning_i <= 1'b1;
		@(posedge clock_i) power_fail_warning_i <= 1'b0;
		sleep(1'b0);
		chk(irq_o, 32'h0, "irq pf masked");
		wr(12'h304, 32'h0000_0004);
		sleep(1'b0);
		chk(irq_o, 32'h1, "irq pf enabled");
		wr(12'h308, 32'hffff_ffff);
		sleep(1'b0);
		chk(irq_o, 32'h0, "irq all cleared");
		$display("test events done");
		wr(12'h194, 32'h0000_00a5);
		sleep(1'b1);
		chk(entries, 32'h1, "entries disabled");
		sleep(1'b0);
		wr(12'h51c, 32'h1234_5678);
		wr(12'h520, 32'hcafe_0001);
		do_reset;
		rd(12'h194, 32'h0);
		rd(12'h51c, 32'h1234_5678);
		rd(12'h520, 32'hcafe_0001);
		$display("test retention done");
		wrap_up;
	end
endmodule
